// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb import tsm_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] want_bus = 8'h00;
  logic want_bit = 1'b0;
  logic [7:0] probe_bus;
  logic probe_bit;
  logic trigger_event;
  logic [3:0] seq_state;
  logic mk_a;
  logic mk_b;
  logic mk_c;
  logic mk_d;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int tests_run = 0;

  always #5 pclk = ~pclk;

  tsm_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .probe_bus(probe_bus), .probe_bit(probe_bit),
    .trigger_event(trigger_event), .seq_state(seq_state), .progress_marker_a(mk_a),
    .progress_marker_b(mk_b), .progress_marker_c(mk_c), .progress_marker_d(mk_d));

  tsm_probe_src src (.pclk(pclk), .presetn(presetn), .want_bus(want_bus),
    .want_bit(want_bit), .probe_bus(probe_bus), .probe_bit(probe_bit));

  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Request held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("[ERR] %0t bus answer missing", $time);
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdx(input logic [ADDR_W-1:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Settle past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic probe(input logic [7:0] b, input logic v);
    @(posedge pclk);
    want_bus <= b;
    want_bit <= v;
  endtask

  task automatic t_reset;
    rdx(OFF_STATUS);
    chk(rd, 32'h0000_0000, "status after reset");
    chk({31'h0, er}, 32'h0, "status error");
    rdx(12'hFFC);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h1, "status write refused");
    $display("test reset done");
  endtask

  task automatic t_oneway;
    // State 0 sets marker a, goes to 1; state 1 fires, clears marker a, back to 0
    wr(OFF_STATE_BASE, 32'h0080_0004);
    wr(OFF_STATE_BASE + 12'h010, 32'h0800_4000);
    wr(OFF_CTRL, 32'h0000_0003);
    cyc(1);
    chk({28'h0, seq_state}, 32'h1, "one-way step");
    chk({31'h0, mk_a}, 32'h1, "marker set");
    chk({31'h0, trigger_event}, 32'h0, "no early trigger");
    cyc(1);
    chk({28'h0, seq_state}, 32'h0, "one-way back");
    chk({31'h0, trigger_event}, 32'h1, "trigger pulse");
    chk({31'h0, mk_a}, 32'h0, "marker cleared");
    wr(OFF_CTRL, 32'h0000_0000);
    $display("test one-way done");
  endtask

  task automatic t_branch;
    wr(OFF_CMP_BASE, 32'h0000_0004);
    wr(OFF_CMP_BASE + 12'h004, 32'h0000_0040);
    wr(OFF_CMP_BASE + 12'h008, 32'h0000_00FF);
    wr(OFF_CMP_BASE + 12'h040, 32'h0000_0006);
    wr(OFF_CMP_BASE + 12'h048, 32'h0000_0001);
    // Three-way: bus >= 40 to state 1, bit rising to state 2, else stay
    wr(OFF_STATE_BASE, 32'h0000_0086);
    wr(OFF_STATE_BASE + 12'h004, 32'h0000_0001);
    wr(OFF_STATE_BASE + 12'h008, 32'h0000_0010);
    wr(OFF_STATE_BASE + 12'h010, 32'h0000_0004);
    wr(OFF_STATE_BASE + 12'h020, 32'h0000_0008);
    probe(8'h3F, 1'b0);
    cyc(3);
    wr(OFF_CTRL, 32'h0000_0003);
    cyc(4);
    chk({28'h0, seq_state}, 32'h0, "default stays");
    probe(8'h40, 1'b1);
    cyc(4);
    chk({28'h0, seq_state}, 32'h1, "first condition wins");
    probe(8'h3F, 1'b0);
    cyc(3);
    wr(OFF_CTRL, 32'h0000_0003);
    cyc(3);
    chk({28'h0, seq_state}, 32'h0, "arm restarts");
    probe(8'h3F, 1'b1);
    cyc(4);
    chk({28'h0, seq_state}, 32'h2, "rising edge branch");
    wr(OFF_CTRL, 32'h0000_0000);
    $display("test branch done");
  endtask

  task automatic t_tally;
    wr(OFF_KCMP_BASE, 32'h0000_0003);
    // Two-way: counts tally a, leaves when the tally equals 3
    wr(OFF_STATE_BASE, 32'h0000_8005);
    wr(OFF_STATE_BASE + 12'h004, 32'h0002_0000);
    wr(OFF_STATE_BASE + 12'h010, 32'h0000_0004);
    wr(OFF_CTRL, 32'h0000_0003);
    cyc(3);
    chk({28'h0, seq_state}, 32'h0, "alternative target");
    cyc(1);
    chk({28'h0, seq_state}, 32'h1, "tally match branch");
    rdx(OFF_TALLY_AB);
    chk(rd, 32'h0000_0004, "tally counted");
    wr(OFF_STATE_BASE + 12'h010, 32'h0008_0004);
    cyc(2);
    rdx(OFF_TALLY_AB);
    chk(rd, 32'h0000_0000, "tally cleared");
    wr(OFF_CTRL, 32'h0000_0000);
    $display("test tally done");
  endtask

  task automatic t_mixed;
    wr(OFF_CMP_BASE + 12'h010, 32'h0000_0001);
    wr(OFF_CMP_BASE + 12'h014, 32'h0000_0055);
    wr(OFF_CMP_BASE + 12'h018, 32'h0000_000F);
    wr(OFF_CMP_BASE + 12'h050, 32'h0000_0007);
    wr(OFF_CMP_BASE + 12'h058, 32'h0000_0001);
    wr(OFF_KCMP_BASE + 12'h004, 32'h0001_0002);
    // State 0 counts tally c, leaves on low-nibble mismatch OR bit falling
    wr(OFF_STATE_BASE, 32'h0102_000D);
    wr(OFF_STATE_BASE + 12'h004, 32'h0001_0022);
    // State 3 stays while bus >= 40 OR tally b != 2, then state 4 fires
    wr(OFF_STATE_BASE + 12'h030, 32'h1201_010D);
    wr(OFF_STATE_BASE + 12'h034, 32'h0016_0001);
    wr(OFF_STATE_BASE + 12'h040, 32'h0400_4010);
    probe(8'h35, 1'b1);
    cyc(3);
    wr(OFF_CTRL, 32'h0000_0003);
    cyc(3);
    chk({28'h0, seq_state}, 32'h0, "masked nibble holds");
    probe(8'h35, 1'b0);
    cyc(4);
    chk({28'h0, seq_state}, 32'h3, "falling edge branch");
    chk({31'h0, mk_b}, 32'h0, "marker b cleared");
    chk({31'h0, mk_c}, 32'h1, "marker c set");
    cyc(1);
    chk({28'h0, seq_state}, 32'h4, "tally not-equal or join");
    rdx(OFF_STATUS);
    chk(rd, 32'h0000_03C4, "status markers fired");
    chk({31'h0, mk_d}, 32'h1, "marker d set");
    chk({31'h0, trigger_event}, 32'h1, "looping trigger stays");
    rdx(OFF_TALLY_AB);
    chk(rd, 32'h0003_0000, "tally b counted");
    rdx(OFF_TALLY_CD);
    chk(rd, 32'h0000_0006, "tally c counted");
    rdx(OFF_STATE_BASE + 12'h030);
    chk(rd, 32'h1201_010D, "program readback");
    $display("test mixed done");
  endtask

  // Reset lands while the machine is still running
  task automatic t_midreset;
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(3);
    chk({23'h0, trigger_event, mk_d, mk_c, mk_b, mk_a, seq_state}, 32'h0, "outputs in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    rdx(OFF_TALLY_CD);
    chk(rd, 32'h0000_0000, "tallies after reset");
    rdx(OFF_STATUS);
    chk(rd, 32'h0000_0000, "status after mid reset");
    $display("test mid reset done");
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_oneway();
    t_branch();
    t_tally();
    t_mixed();
    t_midreset();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire

// *** bench/tsm_probe_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsm_probe_src (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels asked for by the bench
  input wire logic [7:0] want_bus,
  input wire logic want_bit,
  // Probes toward the sequencer
  output logic [7:0] probe_bus,
  output logic probe_bit
);
  // Registered like real user logic, so probes only move after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      probe_bus <= 8'h00;
      probe_bit <= 1'b0;
    end else begin
      probe_bus <= want_bus;
      probe_bit <= want_bit;
    end
  end
endmodule // tsm_probe_src
`default_nettype wire

// *** logic/tsm_pkg.sv ***
`default_nettype none
package tsm_pkg;
  // Sequencer limits
  localparam int MAX_STATES = 16;
  localparam int NUM_TALLY = 4;
  localparam int CNT_W = 16;
  localparam int MAX_CMP = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] FIRST_STATE = 4'h0;

  // APB register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_TALLY_AB = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_TALLY_CD = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_KCMP_BASE = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_STATE_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_CMP_BASE = 12'h200;
  // Word select within a state or comparator block
  localparam logic [1:0] WSEL_ACT = 2'h0;
  localparam logic [1:0] WSEL_COND1 = 2'h1;
  localparam logic [1:0] WSEL_COND2 = 2'h2;
  localparam logic [1:0] WSEL_OP = 2'h0;
  localparam logic [1:0] WSEL_VAL = 2'h1;
  localparam logic [1:0] WSEL_MASK = 2'h2;
  localparam logic [1:0] WSEL_NONE = 2'h3;

  // CTRL fields
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  // STATUS fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FLAG_LSB = 4;
  localparam int STAT_FIRED_BIT = 8;
  localparam int STAT_RUN_BIT = 9;
  // State action word fields
  localparam int ACT_BR_LSB = 0;
  localparam int ACT_T0_LSB = 2;
  localparam int ACT_T1_LSB = 6;
  localparam int ACT_T2_LSB = 10;
  localparam int ACT_TRIG_BIT = 14;
  localparam int ACT_INC_LSB = 15;
  localparam int ACT_CLR_LSB = 19;
  localparam int ACT_FSET_LSB = 23;
  localparam int ACT_FCLR_LSB = 27;
  // Condition word fields
  localparam int COND_SEL_LSB = 0;
  localparam int COND_POR_BIT = 16;
  localparam int COND_USEK_BIT = 17;
  localparam int COND_KSEL_LSB = 18;
  localparam int COND_JOR_BIT = 20;
  // Tally comparator word fields
  localparam int KCMP_NE_BIT = 16;

  typedef enum logic [1:0] {BR_ONE, BR_TWO, BR_THREE} tsm_branch_e;
  typedef enum logic [3:0] {
    CMP_EQ, CMP_NE, CMP_GT, CMP_LT, CMP_GE, CMP_LE,
    CMP_RISE, CMP_FALL, CMP_BOTH, CMP_NONE
  } tsm_cmp_op_e;
endpackage
`default_nettype wire

// *** logic/tsm_sequencer.sv ***
// How it works
// - Up to sixteen states, one branch each.
// - Branch kind chosen per state independently.
// - One-way goes to its target unconditionally.
// - Two-way picks first target or alternative.
// - Three-way: cond one, else two, else default.
// - Four independent sixteen-bit event tallies.
// - Clear action zeroes the selected tally.
// - Increment action adds one to tally.
// - Four markers set, cleared, visible outside.
// - Trigger action raises the trigger event.
// - Probe ports carry 1..16 build-time comparators.
// - Probe compare: eq, ne, gt, lt, ge, le.
// - Constant probe-wide, per-bit don't-care always matches.
// - One-bit probes detect rise, fall, both, none.
// - Conditions only steer two- and three-way branches.
// - One comparator per tally, program wide.
// - Tally comparator tests equal or not-equal.
// - Tally compares use full sixteen bits.
// - Probe results joined by all-AND or all-OR.
// - Probe result joined with tally by AND/OR.
`timescale 1ns/1ps
`default_nettype none
module tsm_sequencer import tsm_pkg::*; #(
  parameter int PROBE_W = 8,
  parameter int NUM_CMP = 4,
  parameter int NUM_BIT_CMP = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Probes from the user design, same clock
  input wire logic [PROBE_W-1:0] probe_bus,
  input wire logic probe_bit,
  // Sequencer outputs
  output logic trigger_event,
  output logic [3:0] seq_state,
  output logic progress_marker_a,
  output logic progress_marker_b,
  output logic progress_marker_c,
  output logic progress_marker_d
);
  // the multi-bit port gets NUM_CMP comparators, the one-bit port the rest
  localparam int NCMP = NUM_CMP + NUM_BIT_CMP;

  typedef struct packed {
    logic [MAX_STATES-1:0][31:0] act;
    logic [MAX_STATES-1:0][31:0] c1;
    logic [MAX_STATES-1:0][31:0] c2;
    logic [NCMP-1:0][3:0] cop;
    logic [NCMP-1:0][PROBE_W-1:0] cval;
    logic [NCMP-1:0][PROBE_W-1:0] cmask;
    logic [NUM_TALLY-1:0][CNT_W-1:0] kval;
    logic [NUM_TALLY-1:0] kne;
    logic [NUM_TALLY-1:0][CNT_W-1:0] cnt;
    logic [NUM_TALLY-1:0] flag;
    logic [3:0] st;
    logic run;
    logic trig;
    logic fired;
    logic prev_bit;
    logic [31:0] rdata;
    logic slverr;
  } tsm_regs_s;

  tsm_regs_s r;
  tsm_regs_s next_r;

  // six relational tests on masked values
  // mask on both sides, don't-care matches
  function automatic logic cmp_hit(input logic [3:0] op, input logic [PROBE_W-1:0] v,
                                   input logic [PROBE_W-1:0] c, input logic [PROBE_W-1:0] m,
                                   input logic one_bit, input logic cur, input logic prv);
    logic [PROBE_W-1:0] a;
    logic [PROBE_W-1:0] b;
    logic res;
    a = v & m;
    b = c & m;
    res = 1'b0;
    case (tsm_cmp_op_e'(op))
      CMP_EQ: res = (a == b);
      CMP_NE: res = (a != b);
      CMP_GT: res = (a > b);
      CMP_LT: res = (a < b);
      CMP_GE: res = (a >= b);
      CMP_LE: res = (a <= b);
      // edge tests are only honoured on the one-bit port
      CMP_RISE: res = one_bit & ~prv & cur;
      CMP_FALL: res = one_bit & prv & ~cur;
      CMP_BOTH: res = one_bit & (prv ^ cur);
      CMP_NONE: res = one_bit & ~(prv ^ cur);
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  logic [MAX_CMP-1:0] cres;
  logic [NUM_TALLY-1:0] kres;

  always_comb begin
    cres = '0;
    for (int i = 0; i < NCMP; i++) begin
      if (i < NUM_CMP) begin
        cres[i] = cmp_hit(r.cop[i], probe_bus, r.cval[i], r.cmask[i], 1'b0, 1'b0, 1'b0);
      end else begin
        cres[i] = cmp_hit(r.cop[i], {{(PROBE_W-1){1'b0}}, probe_bit}, r.cval[i],
                          r.cmask[i], 1'b1, probe_bit, r.prev_bit);
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_TALLY; k++) begin
      // equal, or not-equal via the invert bit
      kres[k] = (r.cnt[k] == r.kval[k]) ^ r.kne[k];
    end
  end

  // Empty probe set is the identity of its operator, so a tally-only
  // condition needs the probe and join operators to match.
  function automatic logic cond_eval(input logic [31:0] w, input logic [MAX_CMP-1:0] hits,
                                     input logic [NUM_TALLY-1:0] kh);
    logic [MAX_CMP-1:0] sel;
    logic pres;
    logic kr;
    logic res;
    sel = w[COND_SEL_LSB +: MAX_CMP];
    // one operator across all selected probe comparators
    pres = w[COND_POR_BIT] ? |(hits & sel) : &(hits | ~sel);
    kr = kh[w[COND_KSEL_LSB +: 2]];
    // independent join operator with the tally result
    if (!w[COND_USEK_BIT]) begin
      res = pres;
    end else if (w[COND_JOR_BIT]) begin
      res = pres | kr;
    end else begin
      res = pres & kr;
    end
    return res;
  endfunction

  // Current state program fields
  logic [31:0] cur_act;
  logic [1:0] cur_br;
  logic [3:0] tgt0;
  logic [3:0] tgt1;
  logic [3:0] tgt2;
  logic [NUM_TALLY-1:0] inc_sel;
  logic [NUM_TALLY-1:0] clr_sel;
  logic [NUM_TALLY-1:0] fset_sel;
  logic [NUM_TALLY-1:0] fclr_sel;
  logic cond1;
  logic cond2;
  logic [3:0] succ;

  // the state index picks one program slot of sixteen
  assign cur_act = r.act[r.st];
  assign cur_br = cur_act[ACT_BR_LSB +: 2];
  assign tgt0 = cur_act[ACT_T0_LSB +: 4];
  assign tgt1 = cur_act[ACT_T1_LSB +: 4];
  assign tgt2 = cur_act[ACT_T2_LSB +: 4];
  assign inc_sel = cur_act[ACT_INC_LSB +: NUM_TALLY];
  assign clr_sel = cur_act[ACT_CLR_LSB +: NUM_TALLY];
  assign fset_sel = cur_act[ACT_FSET_LSB +: NUM_TALLY];
  assign fclr_sel = cur_act[ACT_FCLR_LSB +: NUM_TALLY];
  assign cond1 = cond_eval(r.c1[r.st], cres, kres);
  assign cond2 = cond_eval(r.c2[r.st], cres, kres);

  always_comb begin
    unique case (tsm_branch_e'(cur_br))
      BR_ONE: succ = tgt0;
      BR_TWO: succ = cond1 ? tgt0 : tgt1;
      // priority cond one, then cond two, then default
      BR_THREE: succ = cond1 ? tgt0 : (cond2 ? tgt1 : tgt2);
      // conditions have no effect outside two/three-way
      default: succ = tgt0;
    endcase
  end

  // APB decode
  logic setup;
  logic access;
  logic wr;
  logic arm;
  logic exec;
  logic [3:0] blk;
  logic [1:0] wsel;
  logic hit_state;
  logic hit_cmp;
  logic hit_kcmp;
  logic hit_ro;
  logic mapped;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite & ~r.slverr;
  assign blk = paddr[7:4];
  assign wsel = paddr[3:2];
  assign hit_state = (paddr[11:8] == OFF_STATE_BASE[11:8]) && (wsel != WSEL_NONE);
  assign hit_cmp = (paddr[11:8] == OFF_CMP_BASE[11:8]) && (wsel != WSEL_NONE) && (blk < NCMP);
  assign hit_kcmp = (paddr[11:4] == OFF_KCMP_BASE[11:4]);
  assign hit_ro = (paddr == OFF_STATUS) || (paddr == OFF_TALLY_AB) || (paddr == OFF_TALLY_CD);
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (hit_state || hit_cmp || hit_kcmp || paddr == OFF_CTRL || (hit_ro && !pwrite));
  // arm restarts the program from a clean slate
  assign arm = wr && (paddr == OFF_CTRL) && pwdata[CTRL_ARM_BIT];
  // one step per clock while running and not being re-armed
  assign exec = r.run & ~arm;

  always_comb begin
    next_r = r;
    next_r.trig = 1'b0;
    next_r.prev_bit = probe_bit;

    // Read data is captured in the setup cycle, so the access cycle answers at once
    if (setup) begin
      next_r.slverr = ~mapped;
      next_r.rdata = '0;
      if (paddr == OFF_CTRL) begin
        next_r.rdata[CTRL_RUN_BIT] = r.run;
      end else if (paddr == OFF_STATUS) begin
        next_r.rdata[STAT_STATE_LSB +: 4] = r.st;
        next_r.rdata[STAT_FLAG_LSB +: NUM_TALLY] = r.flag;
        next_r.rdata[STAT_FIRED_BIT] = r.fired;
        next_r.rdata[STAT_RUN_BIT] = r.run;
      end else if (paddr == OFF_TALLY_AB) begin
        next_r.rdata = {r.cnt[1], r.cnt[0]};
      end else if (paddr == OFF_TALLY_CD) begin
        next_r.rdata = {r.cnt[3], r.cnt[2]};
      end else if (hit_kcmp) begin
        next_r.rdata[CNT_W-1:0] = r.kval[wsel];
        next_r.rdata[KCMP_NE_BIT] = r.kne[wsel];
      end else if (hit_state) begin
        unique case (wsel)
          WSEL_ACT: next_r.rdata = r.act[blk];
          WSEL_COND1: next_r.rdata = r.c1[blk];
          default: next_r.rdata = r.c2[blk];
        endcase
      end else if (hit_cmp) begin
        unique case (wsel)
          WSEL_OP: next_r.rdata[3:0] = r.cop[blk];
          WSEL_VAL: next_r.rdata[PROBE_W-1:0] = r.cval[blk];
          default: next_r.rdata[PROBE_W-1:0] = r.cmask[blk];
        endcase
      end
    end

    // Sequencer step
    if (exec) begin
      next_r.st = succ;
      for (int k = 0; k < NUM_TALLY; k++) begin
        // clear has priority over increment in the same state
        if (clr_sel[k]) begin
          next_r.cnt[k] = '0;
        end else if (inc_sel[k]) begin
          next_r.cnt[k] = CNT_W'(r.cnt[k] + CNT_ONE);
        end
        // set wins when one state both sets and clears
        if (fset_sel[k]) begin
          next_r.flag[k] = 1'b1;
        end else if (fclr_sel[k]) begin
          next_r.flag[k] = 1'b0;
        end
      end
      if (cur_act[ACT_TRIG_BIT]) begin
        next_r.trig = 1'b1;
        next_r.fired = 1'b1;
      end
    end

    // Register writes
    if (wr) begin
      if (paddr == OFF_CTRL) begin
        next_r.run = pwdata[CTRL_RUN_BIT];
        // arm clears tallies, markers and restarts at state zero
        if (pwdata[CTRL_ARM_BIT]) begin
          next_r.st = FIRST_STATE;
          next_r.cnt = '0;
          next_r.flag = '0;
          next_r.fired = 1'b0;
        end
      end else if (hit_kcmp) begin
        next_r.kval[wsel] = pwdata[CNT_W-1:0];
        next_r.kne[wsel] = pwdata[KCMP_NE_BIT];
      end else if (hit_state) begin
        unique case (wsel)
          WSEL_ACT: next_r.act[blk] = pwdata;
          WSEL_COND1: next_r.c1[blk] = pwdata;
          default: next_r.c2[blk] = pwdata;
        endcase
      end else if (hit_cmp) begin
        unique case (wsel)
          WSEL_OP: next_r.cop[blk] = pwdata[3:0];
          WSEL_VAL: next_r.cval[blk] = pwdata[PROBE_W-1:0];
          default: next_r.cmask[blk] = pwdata[PROBE_W-1:0];
        endcase
      end
    end
  end

  // reset puts the machine in state zero with everything cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = access;
  assign pslverr = access & r.slverr;
  assign trigger_event = r.trig;
  assign seq_state = r.st;
  assign progress_marker_a = r.flag[0];
  assign progress_marker_b = r.flag[1];
  assign progress_marker_c = r.flag[2];
  assign progress_marker_d = r.flag[3];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_one_way_goto: assert property (
    exec && cur_br == BR_ONE |=> seq_state == $past(tgt0))
    else $error("one-way branch missed its target");
  a_two_way_true: assert property (
    exec && cur_br == BR_TWO && cond1 |=> seq_state == $past(tgt0))
    else $error("two-way true branch wrong");
  a_two_way_false: assert property (
    exec && cur_br == BR_TWO && !cond1 |=> seq_state == $past(tgt1))
    else $error("two-way else branch wrong");
  a_three_way_second: assert property (
    exec && cur_br == BR_THREE && !cond1 && cond2 |=> seq_state == $past(tgt1))
    else $error("three-way elseif branch wrong");
  a_three_way_default: assert property (
    exec && cur_br == BR_THREE && !cond1 && !cond2 |=> seq_state == $past(tgt2))
    else $error("three-way default branch wrong");
  a_tally_clear: assert property (
    exec && clr_sel[0] |=> r.cnt[0] == '0)
    else $error("tally clear did not zero");
  a_tally_incr: assert property (
    exec && inc_sel[2] && !clr_sel[2] |=> r.cnt[2] == CNT_W'($past(r.cnt[2]) + CNT_ONE))
    else $error("tally increment wrong");
  a_marker_set: assert property (
    exec && fset_sel[1] |=> progress_marker_b)
    else $error("marker set action lost");
  a_trigger_fire: assert property (
    exec && cur_act[ACT_TRIG_BIT] |=> trigger_event)
    else $error("trigger action not raised");
  a_trigger_only: assert property (
    !(exec && cur_act[ACT_TRIG_BIT]) |=> !trigger_event)
    else $error("trigger raised without action");
  a_arm_restart: assert property (
    arm |=> seq_state == FIRST_STATE && r.cnt == '0 && r.flag == '0 && !trigger_event)
    else $error("arm did not restart sequencer");
  a_tally_compare: assert property (
    r.cnt[1] != r.kval[1] |-> kres[1] == r.kne[1])
    else $error("tally compare mismatch");

  c_three_way: cover property (exec && cur_br == BR_THREE && !cond1 && cond2);
  c_trigger: cover property (trigger_event);
  c_wrap: cover property (exec && inc_sel[0] && !clr_sel[0] && r.cnt[0] == '1);
  c_edge: cover property (exec && cond1 && r.cop[NCMP-1] == CMP_RISE);
endmodule // tsm_sequencer
`default_nettype wire
